// >>> rtl/dmab_bridge.v
`timescale 1ns/1ps
`include "dmab_map.vh"
module dmab_bridge #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire cpuReq,
	input wire cpuWrite,
	input wire [31:0] cpuAddr,
	input wire [31:0] cpuWdata,
	output wire cpuReady,
	output reg [31:0] cpuRdata,
	output reg cpuErr,
	output reg netReq,
	output reg netWrite,
	output reg [31:0] netAddr,
	output reg [31:0] netWdata,
	input wire netAck,
	input wire [31:0] netRdata,
	input wire netErr,
	output reg locReq,
	output reg locWrite,
	output reg [31:0] locAddr,
	output reg [31:0] locWdata,
	input wire locAck,
	input wire [31:0] locRdata,
	input wire [31:0] rxCheck,
	input wire [31:0] calcCheck,
	output reg doneIrq
);
	localparam S_IDLE = 5'h01;
	localparam S_WAIT = 5'h02;
	localparam S_SRC = 5'h04;
	localparam S_PIPE = 5'h08;
	localparam S_DST = 5'h10;

	reg [31:0] sysAdr_reg;
	reg [31:0] locAdr_reg;
	reg [15:0] count_reg;
	reg [31:0] cmd_reg;
	reg [31:0] setup_reg;
	reg [31:0] poly_reg;
	reg [31:0] qSys_reg;
	reg [31:0] qLoc_reg;
	reg [15:0] qCnt_reg;
	reg [31:0] qCmd_reg;
	reg [31:0] qPoly_reg;
	reg qFull_reg;
	reg [4:0] state_reg;
	reg [2:0] lat_reg;
	reg [15:0] left_reg;
	reg [31:0] srcPtr_reg;
	reg [31:0] dstPtr_reg;
	reg [31:0] word_reg;
	reg [10:0] err_reg;
	reg ptBusy_reg;
	reg ptRead_reg;
	reg cpuDone_reg;
	wire busy;
	wire isReg;
	wire unbuf;
	wire [11:0] ofs;
	wire regAcc;
	wire ptAcc;
	wire fInReady;
	wire fOutValid;
	wire [63:0] fOutData;
	wire fDrain;
	wire bufEn;
	wire dir;
	reg [31:0] rdMux;
	reg [31:0] condWord;

	assign busy = (state_reg != S_IDLE);
	assign dir = cmd_reg[`DMAB_CMD_DIR];
	// Two register aliases that act alike; unbuf is always low on the pass-through path.
	assign isReg = ((cpuAddr & `DMAB_BASE_MASK) == `DMAB_BASE_BUF) |
		((cpuAddr & `DMAB_BASE_MASK) == `DMAB_BASE_UNBUF);
	assign unbuf = ((cpuAddr & `DMAB_BASE_MASK) == `DMAB_BASE_UNBUF);
	assign ofs = cpuAddr[11:0];
	assign regAcc = cpuReq & ce & isReg & ~cpuDone_reg;
	assign bufEn = setup_reg[`DMAB_SET_BUFWR];
	// Buffered writes enter the FIFO; reads bypass it once it is empty.
	assign ptAcc = cpuReq & ce & ~isReg & ~cpuDone_reg & cpuWrite & bufEn
		& fInReady;
	assign fDrain = ce & fOutValid & ~ptBusy_reg & ~busy;
	// Ready is one cycle after a register or buffered-write request, giving the two-cycle base.
	assign cpuReady = cpuDone_reg;

	dmab_fifo #(
		.WIDTH(64),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) wbuf (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.inValid(ptAcc),
		.inReady(fInReady),
		.inData({cpuAddr, cpuWdata}),
		.outValid(fOutValid),
		.outReady(fDrain),
		.outData(fOutData)
	);

	// Condition word built field by field; unused bits read as zero.
	always @* begin
		condWord = 32'h00000000;
		condWord[`DMAB_ST_BUSY] = busy;
		condWord[`DMAB_ST_QFULL] = qFull_reg;
		condWord[`DMAB_ST_PROG] = busy | ptBusy_reg;
		condWord[`DMAB_ST_BWR] = fOutValid;
		condWord[`DMAB_ST_ERR +: `DMAB_ERR_W] = err_reg;
	end

	// Register readback is always available, busy or not.
	always @* begin
		case (ofs)
		`DMAB_OFS_SYSADR: rdMux = sysAdr_reg;
		`DMAB_OFS_LOCADR: rdMux = locAdr_reg;
		`DMAB_OFS_COUNT: rdMux = {16'h0000, count_reg};
		`DMAB_OFS_CMD: rdMux = cmd_reg;
		`DMAB_OFS_COND: rdMux = condWord;
		`DMAB_OFS_SETUP: rdMux = setup_reg;
		`DMAB_OFS_POLY: rdMux = poly_reg;
		`DMAB_OFS_COMPUTED_CHECK_VALUE: rdMux = calcCheck;
		`DMAB_OFS_RECEIVED_CHECK_VALUE: rdMux = rxCheck;
		`DMAB_OFS_QSYS: rdMux = qSys_reg;
		`DMAB_OFS_QLOC: rdMux = qLoc_reg;
		`DMAB_OFS_QCNT: rdMux = {16'h0000, qCnt_reg};
		`DMAB_OFS_QCMD: rdMux = qCmd_reg;
		`DMAB_OFS_QPOLY: rdMux = qPoly_reg;
		default: rdMux = 32'h00000000;
		endcase
	end

	// Processor side: registers and buffered writes finish at once.
	always @(posedge clk) begin
		if (rst) begin
			cpuDone_reg <= 1'b0;
			cpuRdata <= 32'h00000000;
			cpuErr <= 1'b0;
			ptBusy_reg <= 1'b0;
			ptRead_reg <= 1'b0;
			netReq <= 1'b0;
			netWrite <= 1'b0;
			netAddr <= 32'h00000000;
			netWdata <= 32'h00000000;
			sysAdr_reg <= 32'h00000000;
			locAdr_reg <= 32'h00000000;
			count_reg <= 16'h0000;
			cmd_reg <= `DMAB_CMD_RESET;
			setup_reg <= `DMAB_SETUP_RESET;
			poly_reg <= 32'h00000000;
			qSys_reg <= 32'h00000000;
			qLoc_reg <= 32'h00000000;
			qCnt_reg <= 16'h0000;
			qCmd_reg <= `DMAB_CMD_RESET;
			qPoly_reg <= 32'h00000000;
			qFull_reg <= 1'b0;
			state_reg <= S_IDLE;
			lat_reg <= 3'h0;
			left_reg <= 16'h0000;
			srcPtr_reg <= 32'h00000000;
			dstPtr_reg <= 32'h00000000;
			word_reg <= 32'h00000000;
			err_reg <= 11'h000;
			locReq <= 1'b0;
			locWrite <= 1'b0;
			locAddr <= 32'h00000000;
			locWdata <= 32'h00000000;
			doneIrq <= 1'b0;
		end else if (ce) begin
			cpuDone_reg <= 1'b0;
			doneIrq <= 1'b0;
			if (regAcc) begin
				cpuDone_reg <= 1'b1;
				cpuRdata <= rdMux;
				cpuErr <= 1'b0;
				if (cpuWrite & busy) begin
					// Active request: redirect to queued copies.
					case (ofs)
					`DMAB_OFS_SYSADR: qSys_reg <= cpuWdata;
					`DMAB_OFS_LOCADR: qLoc_reg <= cpuWdata;
					`DMAB_OFS_COUNT: qCnt_reg <= cpuWdata[15:0];
					`DMAB_OFS_POLY: qPoly_reg <= cpuWdata;
					`DMAB_OFS_CMD: begin
						// Only the abort bit touches the active one.
						qCmd_reg <= cpuWdata;
						if (cpuWdata[`DMAB_CMD_START]) begin
							qFull_reg <= 1'b1;
						end
						if (cpuWdata[`DMAB_CMD_ABORT]) begin
							state_reg <= S_IDLE;
							locReq <= 1'b0;
							netReq <= 1'b0;
						end
					end
					default: cpuErr <= 1'b1;
					endcase
				end else if (cpuWrite) begin
					case (ofs)
					`DMAB_OFS_SYSADR: sysAdr_reg <= cpuWdata;
					`DMAB_OFS_LOCADR: locAdr_reg <= cpuWdata;
					`DMAB_OFS_COUNT: count_reg <= cpuWdata[15:0];
					`DMAB_OFS_SETUP: setup_reg <= cpuWdata;
					`DMAB_OFS_POLY: poly_reg <= cpuWdata;
					`DMAB_OFS_CMD: begin
						cmd_reg <= cpuWdata;
						if (cpuWdata[`DMAB_CMD_START]) begin
							state_reg <= S_WAIT;
							lat_reg <= `DMAB_START_LAT;
						end
					end
					default: cpuErr <= 1'b0;
					endcase
				end
			end else if (ptAcc) begin
				cpuDone_reg <= 1'b1;
				cpuErr <= 1'b0;
			end else if (cpuReq & ~isReg & ~cpuDone_reg & ~ptBusy_reg
				& ~fOutValid & ~busy & (cpuWrite ? ~bufEn | unbuf
				| ~fInReady : 1'b1)) begin
				// Direct pass-through; reads wait for buffer drain.
				ptBusy_reg <= 1'b1;
				ptRead_reg <= ~cpuWrite;
				netReq <= 1'b1;
				netWrite <= cpuWrite;
				netAddr <= cpuAddr;
				netWdata <= cpuWdata;
			end
			// The drain stands apart from the chain above: the buffer pops
			// whenever fDrain is high, so the word must always be issued.
			if (fDrain) begin
				ptBusy_reg <= 1'b1;
				ptRead_reg <= 1'b0;
				netReq <= 1'b1;
				netWrite <= 1'b1;
				netAddr <= fOutData[63:32];
				netWdata <= fOutData[31:0];
			end
			// Network completion of a pass-through operation.
			if (ptBusy_reg & netAck) begin
				ptBusy_reg <= 1'b0;
				netReq <= 1'b0;
				if (ptRead_reg | ~bufEn) begin
					cpuDone_reg <= 1'b1;
					cpuRdata <= netRdata;
					cpuErr <= netErr;
				end
			end
			// Block transfer engine.
			case (state_reg)
			S_IDLE: begin
				// A start queued in the very cycle the last transfer ended
				// lands here; without this it would never be served.
				if (qFull_reg) begin
					sysAdr_reg <= qSys_reg;
					locAdr_reg <= qLoc_reg;
					count_reg <= qCnt_reg;
					cmd_reg <= qCmd_reg;
					poly_reg <= qPoly_reg;
					qFull_reg <= 1'b0;
					state_reg <= S_WAIT;
					lat_reg <= `DMAB_START_LAT;
				end
			end
			S_WAIT: begin
				if (lat_reg != `DMAB_LAT_LAST) begin
					lat_reg <= lat_reg - 1'b1;
				end else if (~ptBusy_reg) begin
					state_reg <= S_SRC;
					// The last error code stays readable until a new start.
					err_reg <= {`DMAB_ERR_W{1'b0}};
					left_reg <= count_reg;
					srcPtr_reg <= dir ? locAdr_reg : sysAdr_reg;
					dstPtr_reg <= dir ? sysAdr_reg : locAdr_reg;
				end
			end
			S_SRC: begin
				if (left_reg == 16'h0000) begin
					doneIrq <= 1'b1;
					if (qFull_reg) begin
						// Promote queued request; params stay otherwise.
						sysAdr_reg <= qSys_reg;
						locAdr_reg <= qLoc_reg;
						count_reg <= qCnt_reg;
						cmd_reg <= qCmd_reg;
						poly_reg <= qPoly_reg;
						qFull_reg <= 1'b0;
						state_reg <= S_WAIT;
						lat_reg <= `DMAB_START_LAT;
					end else begin
						state_reg <= S_IDLE;
					end
				end else if (dir) begin
					locReq <= 1'b1;
					locWrite <= 1'b0;
					locAddr <= srcPtr_reg;
					if (locReq & locAck) begin
						locReq <= 1'b0;
						word_reg <= locRdata;
						state_reg <= S_PIPE;
					end
				end else begin
					netReq <= 1'b1;
					netWrite <= 1'b0;
					netAddr <= srcPtr_reg;
					if (netReq & netAck) begin
						netReq <= 1'b0;
						word_reg <= netRdata;
						if (netErr) begin
							err_reg <= `DMAB_ERR_NET;
						end
						state_reg <= S_PIPE;
					end
				end
			end
			S_PIPE: begin
				// Second pipeline stage before the destination bus.
				state_reg <= S_DST;
				if (dir) begin
					netReq <= 1'b1;
					netWrite <= 1'b1;
					netAddr <= dstPtr_reg;
					netWdata <= word_reg;
				end else begin
					locReq <= 1'b1;
					locWrite <= 1'b1;
					locAddr <= dstPtr_reg;
					locWdata <= word_reg;
				end
			end
			S_DST: begin
				if ((dir & netAck) | (~dir & locAck)) begin
					netReq <= 1'b0;
					locReq <= 1'b0;
					if (dir & netErr) begin
						err_reg <= `DMAB_ERR_NET;
					end
					srcPtr_reg <= srcPtr_reg + `DMAB_WORD_STEP;
					dstPtr_reg <= dstPtr_reg + `DMAB_WORD_STEP;
					// A short tail is clamped so the count cannot wrap.
					left_reg <= (left_reg > `DMAB_LEN_STEP) ?
						left_reg - `DMAB_LEN_STEP : 16'h0000;
					state_reg <= S_SRC;
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule

// >>> include/dmab_map.vh
`ifndef DMAB_MAP_VH
`define DMAB_MAP_VH
// Register word offsets (byte addresses within the register block).
`define DMAB_OFS_SYSADR 12'h000
`define DMAB_OFS_LOCADR 12'h004
`define DMAB_OFS_COUNT 12'h008
`define DMAB_OFS_CMD 12'h00C
`define DMAB_OFS_COND 12'h010
`define DMAB_OFS_SETUP 12'h014
`define DMAB_OFS_POLY 12'h018
`define DMAB_OFS_COMPUTED_CHECK_VALUE 12'h01C
`define DMAB_OFS_RECEIVED_CHECK_VALUE 12'h020
`define DMAB_OFS_QSYS 12'h100
`define DMAB_OFS_QLOC 12'h104
`define DMAB_OFS_QCNT 12'h108
`define DMAB_OFS_QCMD 12'h10C
`define DMAB_OFS_QPOLY 12'h118
// Register block aliases: both reach the same registers and act alike.
`define DMAB_BASE_BUF 32'h40000000
`define DMAB_BASE_UNBUF 32'h30000000
`define DMAB_BASE_MASK 32'hFFFFF000
// Command register fields.
`define DMAB_CMD_START 0
`define DMAB_CMD_ABORT 1
`define DMAB_CMD_RESUME 2
`define DMAB_CMD_DIR 4
`define DMAB_CMD_RESET 32'h00000380
// Condition register fields.
`define DMAB_ST_BUSY 0
`define DMAB_ST_QFULL 1
`define DMAB_ST_PROG 2
`define DMAB_ST_BWR 4
`define DMAB_ST_ERR 10
`define DMAB_ERR_W 11
// Error code reported when the network answers with an error.
`define DMAB_ERR_NET 11'h001
// Global setup fields.
`define DMAB_SET_BUFWR 1
`define DMAB_SETUP_RESET 32'h000003E2
// Length field width.
`define DMAB_LEN_W 16
// Timing: least start latency in clocks, latency counter width and last count.
`define DMAB_START_LAT 3'h4
`define DMAB_LAT_W 3
`define DMAB_LAT_LAST 3'h1
// Pointer and length step for one 32-bit word.
`define DMAB_WORD_STEP 32'h00000004
`define DMAB_LEN_STEP 16'h0004
`endif

// >>> rtl/dmab_fifo.v
`timescale 1ns/1ps
module dmab_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr_reg;
	reg [AW-1:0] rdPtr_reg;
	reg [AW:0] count_reg;
	wire doWr;
	wire doRd;

	// Full and empty come straight from the occupancy count.
	assign inReady = (count_reg != DEPTH);
	assign outValid = (count_reg != 0);
	assign outData = mem[rdPtr_reg];
	assign doWr = inValid & inReady & ce;
	assign doRd = outValid & outReady & ce;

	// Storage array carries no reset; only pointers and the count need a known value.
	always @(posedge clk) begin
		if (doWr) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	// Pointers wrap naturally because DEPTH is a power of two.
	always @(posedge clk) begin
		if (rst) begin
			wrPtr_reg <= {AW{1'b0}};
			rdPtr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (doWr) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (doRd) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
			if (doWr & ~doRd) begin
				count_reg <= count_reg + 1'b1;
			end else if (doRd & ~doWr) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule

// >>> sim/dmab_monitor.sv
`timescale 1ns/1ps
module dmab_monitor (
	input wire clk,
	input wire rst,
	input wire cpuReq,
	input wire cpuWrite,
	input wire [31:0] cpuAddr,
	input wire [31:0] cpuWdata,
	input wire cpuReady,
	input wire [31:0] cpuRdata,
	input wire cpuErr,
	input wire netReq,
	input wire netWrite,
	input wire [31:0] netAddr,
	input wire netAck,
	input wire [31:0] netRdata,
	input wire netErr,
	input wire locReq,
	input wire locWrite,
	input wire [31:0] locWdata,
	input wire doneIrq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	reg [1:0] startCnt;
	wire regHit = cpuReq && cpuAddr[31:12] == 20'h40000;
	wire cmdHit = regHit && cpuWrite && cpuAddr[11:0] == 12'h00C;
	wire startAcc = cpuReady && !cpuErr && cpuWdata[0] && cmdHit;
	// Block requests in flight, so start latency is judged only from idle.
	always @(posedge clk) begin
		if (rst)
			startCnt <= 2'h0;
		else
			startCnt <= startCnt + {1'b0, startAcc} - {1'b0, doneIrq};
	end
	// Relations between requests and answers at the ports.
	property p_base; $rose(cpuReq) |-> !cpuReady; endproperty
	a_base: assert property (p_base) else $error("early answer");
	property p_reg; regHit && !cpuReady |=> cpuReady; endproperty
	a_reg: assert property (p_reg) else $error("slow register");
	property p_rd;
		netAck && netReq && !netWrite && !netErr && cpuReq && !cpuWrite &&
		cpuAddr == netAddr |=> cpuReady && cpuRdata == $past(netRdata);
	endproperty
	a_rd: assert property (p_rd) else $error("read answer");
	property p_hold; netReq && !netAck |=> netReq && $stable(netAddr); endproperty
	a_hold: assert property (p_hold) else $error("net dropped");
	property p_d2l;
		netAck && !netWrite && !(cpuReq && !cpuWrite) |->
		##2 locReq && locWrite && locWdata == $past(netRdata, 2);
	endproperty
	a_d2l: assert property (p_d2l) else $error("data delay");
	property p_smin;
		startAcc && startCnt == 2'h0 |=> (!locReq && !netReq) [*2];
	endproperty
	a_smin: assert property (p_smin) else $error("start early");
	property p_smax;
		startAcc && startCnt == 2'h0 |-> ##[3:21] (locReq || netReq);
	endproperty
	a_smax: assert property (p_smax) else $error("start late");
	property p_done; doneIrq |-> startCnt != 2'h0; endproperty
	a_done: assert property (p_done) else $error("stray done");
	property p_err;
		regHit && !cpuReady && !doneIrq && cpuWrite && startCnt != 2'h0 &&
		cpuAddr[11:0] == 12'h014 |=> cpuReady && cpuErr;
	endproperty
	a_err: assert property (p_err) else $error("busy write");
	c_start: cover property (startAcc);
	c_err: cover property (cpuErr);
	c_done: cover property (doneIrq);
endmodule
bind dmab_bridge dmab_monitor mon (.clk(clk), .rst(rst), .cpuReq(cpuReq),
	.cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
	.cpuReady(cpuReady), .cpuRdata(cpuRdata), .cpuErr(cpuErr),
	.netReq(netReq), .netWrite(netWrite), .netAddr(netAddr),
	.netAck(netAck), .netRdata(netRdata), .netErr(netErr),
	.locReq(locReq), .locWrite(locWrite), .locWdata(locWdata),
	.doneIrq(doneIrq));

// >>> sim/dmab_far_model.sv
`timescale 1ns/1ps
module dmab_far_model (
	input wire clk,
	input wire rst,
	input wire slow,
	input wire netReq,
	input wire netWrite,
	input wire [31:0] netAddr,
	input wire [31:0] netWdata,
	output reg netAck = 1'b0,
	output reg [31:0] netRdata = 32'h0,
	output reg netErr = 1'b0,
	input wire locReq,
	input wire locWrite,
	input wire [31:0] locAddr,
	output reg locAck = 1'b0,
	output reg [31:0] locRdata = 32'h0
);
	reg [31:0] mem [0:15];
	reg [2:0] waitCnt;
	integer i;
	// Network slave: one ack pulse per request, held off while slow.
	// Idle read data flips every cycle so a stale word never matches.
	always @(posedge clk) begin
		netAck <= 1'b0;
		netErr <= 1'b0;
		netRdata <= ~netRdata;
		if (rst) begin
			waitCnt <= 3'h0;
			for (i = 0; i < 16; i = i + 1)
				mem[i] <= {8{i[3:0]}};
		end else if (netReq && !netAck) begin
			if (waitCnt != 3'h0)
				waitCnt <= waitCnt - 3'h1;
			else begin
				netAck <= 1'b1;
				netErr <= netAddr[31:28] == 4'hE;
				waitCnt <= slow ? 3'h6 : 3'h0;
				if (netWrite)
					mem[netAddr[5:2]] <= netWdata;
				else
					netRdata <= mem[netAddr[5:2]];
			end
		end
	end
	// Local memory answers the cycle after a request.
	always @(posedge clk) begin
		locAck <= locReq && !locAck && !rst;
		if (locReq && !locAck && !locWrite)
			locRdata <= {locAddr[15:0], ~locAddr[15:0]};
		else
			locRdata <= ~locRdata;
	end
endmodule

// >>> sim/dmab_tb.sv
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg cpuReq = 1'b0, cpuWrite = 1'b0, slow = 1'b0;
	reg [31:0] cpuAddr = 32'h0, cpuWdata = 32'h0, d;
	reg [31:0] rxCheck = 32'h0, calcCheck = 32'h0;
	reg [31:0] tbMem [0:15];
	reg [33:0] e;
	reg [33:0] cpuQ [$];
	reg [63:0] netQ [$];
	reg [63:0] locQ [$];
	wire cpuReady, cpuErr, netReq, netWrite, netAck, netErr;
	wire locReq, locWrite, locAck, doneIrq;
	wire [31:0] cpuRdata, netAddr, netWdata, netRdata;
	wire [31:0] locAddr, locWdata, locRdata;
	integer errorCnt = 0, samplesChecked = 0, doneCnt = 0, i, n;
	integer seed = 32'h666FC3FE;
	always #5 clk = ~clk;
	dmab_bridge #(.FIFO_DEPTH(16), .FIFO_AW(4)) DUT (.clk(clk), .rst(rst),
		.ce(1'b1), .cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
		.cpuWdata(cpuWdata), .cpuReady(cpuReady), .cpuRdata(cpuRdata),
		.cpuErr(cpuErr), .netReq(netReq), .netWrite(netWrite),
		.netAddr(netAddr), .netWdata(netWdata), .netAck(netAck),
		.netRdata(netRdata), .netErr(netErr), .locReq(locReq),
		.locWrite(locWrite), .locAddr(locAddr), .locWdata(locWdata),
		.locAck(locAck), .locRdata(locRdata), .rxCheck(rxCheck),
		.calcCheck(calcCheck), .doneIrq(doneIrq));
	dmab_far_model far (.clk(clk), .rst(rst), .slow(slow), .netReq(netReq),
		.netWrite(netWrite), .netAddr(netAddr), .netWdata(netWdata),
		.netAck(netAck), .netRdata(netRdata), .netErr(netErr),
		.locReq(locReq), .locWrite(locWrite), .locAddr(locAddr),
		.locAck(locAck), .locRdata(locRdata));
	task stopTest;
		begin
			if (errorCnt == 0 && samplesChecked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task chk(input [63:0] seen, input [63:0] exp, input [23:0] what);
		begin
			samplesChecked = samplesChecked + 1;
			if (seen !== exp) begin
				errorCnt = errorCnt + 1;
				$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	// One access, held until ready; its expectation is queued first.
	task acc(input w, input [31:0] a, input [31:0] wd, input [33:0] x);
		begin
			cpuQ.push_back(x);
			cpuReq = 1'b1;
			cpuWrite = w;
			cpuAddr = a;
			cpuWdata = wd;
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (cpuReady !== 1'b1 && n < 400);
			if (n >= 400)
				chk(0, 1, "hng");
			#1 cpuReq = 1'b0;
			@(posedge clk);
			#1;
		end
	endtask
	task wr(input [31:0] a, input [31:0] wd);
		acc(1'b1, a, wd, 34'h0);
	endtask
	task rd(input [31:0] a, input [31:0] x);
		acc(1'b0, a, 32'h0, {2'b10, x});
	endtask
	// Pass-through write, mirrored into the network image.
	task pw(input [3:0] k, input [31:0] wd);
		begin
			netQ.push_back({32'h60000000 + {k, 2'b00}, wd});
			tbMem[k] = wd;
			wr(32'h60000000 + {k, 2'b00}, wd);
		end
	endtask
	task waitDone(input integer c);
		begin
			n = 0;
			while (doneCnt < c && n < 2000) begin
				@(posedge clk);
				n = n + 1;
			end
			chk(doneCnt, c, "irq");
			@(posedge clk);
			#1;
		end
	endtask
	// Each processor answer and each network or local write retires the oldest expectation.
	always @(posedge clk) begin
		if (doneIrq === 1'b1)
			doneCnt = doneCnt + 1;
		if (cpuReady === 1'b1) begin
			e = cpuQ.pop_front();
			chk({cpuErr, e[33] ? cpuRdata : e[31:0]}, e[32:0], "cpu");
		end
		if (netAck && netWrite)
			chk({netAddr, netWdata}, netQ.pop_front(), "net");
		if (locAck && locWrite)
			chk({locAddr, locWdata}, locQ.pop_front(), "loc");
	end
	initial begin
		for (i = 0; i < 16; i = i + 1)
			tbMem[i] = {8{i[3:0]}};
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		// Reset contents, then set-up registers written and read back.
		rd(32'h4000000C, 32'h380);
		rd(32'h40000014, 32'h3E2);
		rd(32'h40000010, 32'h0);
		for (i = 0; i < 3; i = i + 1) begin
			d = $random(seed);
			wr(32'h40000000 + 4 * i, d);
			rd(32'h40000000 + 4 * i, i == 2 ? {16'h0, d[15:0]} : d);
		end
		wr(32'h30000018, d);
		rd(32'h40000018, d);
		rxCheck = $random(seed);
		calcCheck = $random(seed);
		rd(32'h4000001C, calcCheck);
		rd(32'h40000020, rxCheck);
		// A slow network lets twenty writes back up in the buffer without filling it.
		slow = 1'b1;
		for (i = 0; i < 20; i = i + 1)
			pw(i[3:0], $random(seed));
		rd(32'h6000000C, tbMem[3]);
		slow = 1'b0;
		wr(32'h40000014, 32'h3E0);
		pw(4'h5, $random(seed));
		wr(32'h40000014, 32'h3E2);
		rd(32'h40000010, 32'h0);
		acc(1'b0, 32'hE0000000, 32'h0, {2'b01, 32'h0});
		// Block read to local memory with a second request queued.
		slow = 1'b1;
		wr(32'h40000000, 32'h60000000);
		wr(32'h40000004, 32'h100);
		wr(32'h40000008, 32'h10);
		for (i = 0; i < 6; i = i + 1)
			locQ.push_back(i < 4 ? {32'h100 + 4 * i, tbMem[i]} :
				{32'h1F0 + 4 * i, tbMem[i + 4]});
		wr(32'h4000000C, 32'h381);
		acc(1'b1, 32'h40000014, 32'h3E2, {2'b01, 32'h0});
		rd(32'h40000010, 32'h5);
		wr(32'h40000000, 32'h60000020);
		wr(32'h40000004, 32'h200);
		wr(32'h40000008, 32'h8);
		wr(32'h4000000C, 32'h381);
		rd(32'h40000100, 32'h60000020);
		waitDone(2);
		rd(32'h40000008, 32'h8);
		// Block write from local memory out to the network.
		slow = 1'b0;
		wr(32'h40000000, 32'h60000030);
		wr(32'h40000004, 32'h300);
		for (i = 0; i < 2; i = i + 1) begin
			d = 32'h300 + 4 * i;
			netQ.push_back({32'h60000030 + 4 * i, d[15:0], ~d[15:0]});
		end
		wr(32'h4000000C, 32'h391);
		waitDone(3);
		stopTest;
	end
	// Cuts a hang short far beyond the expected run length.
	initial begin
		#200000;
		errorCnt = errorCnt + 1;
		stopTest;
	end
endmodule
